// ---- serial_unit_defs.vh ----
// register offsets, field positions, reset values and sync layout of the serial unit
`ifndef SERIAL_UNIT_DEFS_VH
`define SERIAL_UNIT_DEFS_VH

`define OFS_PRIMARY_CONTROL   8'h00
`define OFS_SECONDARY_CONTROL 8'h04
`define OFS_IRQ_ENABLE_SET    8'h16
`define OFS_SYNC_STATUS       8'h1C
`define OFS_ADDRESS_MATCH     8'h24

`define RST_PRIMARY_CONTROL   32'h00000000
`define RST_SECONDARY_CONTROL 32'h00000000
`define RST_ADDRESS_MATCH     32'h00000000
`define RST_IRQ_ENABLE        8'h00

`define BIT_SOFT_RESET        0
`define BIT_ENABLE            1
`define BIT_DATA_ORDER        30
`define BIT_CLOCK_POLARITY    29
`define BIT_CLOCK_PHASE       28
`define FRAME_FORMAT_HI       27
`define FRAME_FORMAT_LO       24
`define DATA_IN_PINOUT_HI     21
`define DATA_IN_PINOUT_LO     20
`define BIT_RX_ENABLE         17

`define FORMAT_PLAIN          4'h0
`define FORMAT_WITH_ADDRESS   4'h2

`define IRQ_EN_MASTER_ON_BUS  0
`define IRQ_EN_SLAVE_ON_BUS   1
`define IRQ_EN_ERROR          7
`define IRQ_EN_WRITABLE       8'h83

`define SYNC_SOFT_RESET       0
`define SYNC_ENABLE           1
`define SYNC_SECONDARY        2
`define SYNC_CHANNELS         3

`define FIFO_WIDTH            8
`define FIFO_DEPTH            2

`endif

// ---- fifo2.v ----
// two-entry first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "serial_unit_defs.vh"

module fifo2 (
    input  wire                     mclk,
    input  wire                     reset_n,
    input  wire                     flush,
    input  wire                     inValid,
    output wire                     inReady,
    input  wire [`FIFO_WIDTH-1:0]   inData,
    output wire                     outValid,
    input  wire                     outReady,
    output reg  [`FIFO_WIDTH-1:0]   outData
);
    reg  [`FIFO_WIDTH-1:0] spare_q;
    reg  [1:0]             count_q;
    wire                   push;
    wire                   pop;

    // head word always sits in outData so the data output comes from a flop
    assign inReady  = (count_q != 2'd2);
    assign outValid = (count_q != 2'd0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge mclk) begin
        if (!reset_n || flush) begin
            count_q <= 2'd0;
            spare_q <= {`FIFO_WIDTH{1'b0}};
            outData <= {`FIFO_WIDTH{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count_q == 2'd0)
                        outData <= inData;
                    else
                        spare_q <= inData;
                    count_q <= count_q + 2'd1;
                end
                2'b01: begin
                    outData <= spare_q;
                    count_q <= count_q - 2'd1;
                end
                2'b11: begin
                    // simultaneous push and pop: head moves on, new word becomes head when it was alone, else sits behind it
                    if (count_q == 2'd1)
                        outData <= inData;
                    else begin
                        outData <= spare_q;
                        spare_q <= inData;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end
endmodule // fifo2

// ---- serial_unit.v ----
// serial unit: register slave, sync busy handshakes and spi slave receive path
// Behaviour
// (R01) when enabled, writing secondary_control sets its busy flag until synchronized
// (R02) write to secondary_control while its busy flag is set gets a bus error
// (R03) writing the enable bit sets the enable busy flag until synchronized; code sets it only when the written value differs from the current bit
// (R04) during enable sync, writes other than soft_reset are dropped with error
// (R05) writing soft_reset sets the reset busy flag until synchronized
// (R06) during reset sync, all writes are dropped and answered with error
// (R07) data order 0 shifts msb first, 1 shifts lsb first
// (R08) clock_polarity sets serial clock idle level and leading edge direction
// (R09) clock_phase 0 samples leading, 1 samples trailing edge
// (R10) polarity and phase apply directly, no busy flag
// (R11) frame_format 0x0 plain frame, 0x2 frame with address, others reserved
// (R12) with address format, first received byte compared with address match
// (R13) data_in_pinout picks the pad carrying serial_input
// (R14) data_in_pinout applies directly, no busy flag
// (R15) writing 1 at bit 7 of irq enable set enables error interrupt
// (R16) writing 1 at bit 1 enables slave on bus interrupt
// (R17) writing 1 at bit 0 enables master on bus interrupt
// (R18) busy clears only after value crossed to core and was acknowledged back
`timescale 1ns/1ps
`include "serial_unit_defs.vh"

module serial_unit (
    input  wire                    mclk,
    input  wire                    reset_n,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [7:0]              paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire                    sck,
    input  wire                    selectN,
    input  wire [3:0]              pad,
    output reg                     misoOut,
    output reg                     misoOe,
    input  wire [7:0]              txData,
    output wire                    rxValid,
    input  wire                    rxReady,
    output wire [7:0]              rxData,
    output reg                     rxOverflow,
    output reg  [7:0]              irqEnable
);
    reg  [31:0]                primary_q;
    reg  [31:0]                secondary_q;
    reg  [31:0]                addrMatch_q;
    reg  [`SYNC_CHANNELS-1:0]  busy_q;
    reg  [`SYNC_CHANNELS-1:0]  req_q;
    reg  [`SYNC_CHANNELS-1:0]  reqS1_q;
    reg  [`SYNC_CHANNELS-1:0]  reqS2_q;
    reg  [`SYNC_CHANNELS-1:0]  ack_q;
    reg  [`SYNC_CHANNELS-1:0]  ackS1_q;
    reg  [`SYNC_CHANNELS-1:0]  ackS2_q;
    reg                        coreEnable_q;
    reg  [31:0]                coreSecondary_q;
    wire [`SYNC_CHANNELS-1:0]  done;
    wire [`SYNC_CHANNELS-1:0]  coreSeen;
    wire                       wrAccess;
    wire                       hitPrimary;
    wire                       hitSecondary;
    wire                       resetWrite;
    reg                        wrError;
    wire                       wrOk;

    // a completed sync is an acknowledge toggle back on the bus side matching the request
    assign done     = busy_q & ~(ackS2_q ^ req_q);           // R18
    assign coreSeen = reqS2_q ^ ack_q;

    assign pready       = 1'b1;
    assign wrAccess     = psel & penable & pwrite;
    assign hitPrimary   = (paddr == `OFS_PRIMARY_CONTROL);
    assign hitSecondary = (paddr == `OFS_SECONDARY_CONTROL);
    assign resetWrite   = hitPrimary & pwdata[`BIT_SOFT_RESET];

    // error answer for writes that sync in progress forbids
    always @* begin
        wrError = 1'b0;
        if (busy_q[`SYNC_SOFT_RESET])
            wrError = 1'b1;                                  // R06
        else if (busy_q[`SYNC_ENABLE] && !resetWrite)
            wrError = 1'b1;                                  // R04
        else if (hitSecondary && busy_q[`SYNC_SECONDARY])
            wrError = 1'b1;                                  // R02
    end
    assign pslverr = wrAccess & wrError;
    assign wrOk    = wrAccess & ~wrError;

    // bus side registers and busy flags
    always @(posedge mclk) begin
        if (!reset_n || done[`SYNC_SOFT_RESET]) begin
            // soft reset returns registers and busy flags, not the request toggles, once the core has taken it
            primary_q   <= `RST_PRIMARY_CONTROL;
            secondary_q <= `RST_SECONDARY_CONTROL;
            addrMatch_q <= `RST_ADDRESS_MATCH;
            irqEnable   <= `RST_IRQ_ENABLE;
            busy_q      <= {`SYNC_CHANNELS{1'b0}};
            if (!reset_n)
                req_q <= {`SYNC_CHANNELS{1'b0}};
        end else begin
            busy_q <= busy_q & ~done;                        // R18
            if (wrOk && hitPrimary) begin
                if (pwdata[`BIT_SOFT_RESET]) begin
                    primary_q[`BIT_SOFT_RESET] <= 1'b1;
                    busy_q[`SYNC_SOFT_RESET]   <= 1'b1;      // R05
                    req_q[`SYNC_SOFT_RESET]    <= ~req_q[`SYNC_SOFT_RESET];
                end else begin
                    // polarity, phase, order, format and pinout land at once
                    primary_q <= pwdata;                     // R10 R14
                    if (pwdata[`BIT_ENABLE] != primary_q[`BIT_ENABLE]) begin
                        busy_q[`SYNC_ENABLE] <= 1'b1;        // R03
                        req_q[`SYNC_ENABLE]  <= ~req_q[`SYNC_ENABLE];
                    end
                end
            end
            if (wrOk && hitSecondary) begin
                secondary_q <= pwdata;
                if (primary_q[`BIT_ENABLE]) begin
                    busy_q[`SYNC_SECONDARY] <= 1'b1;         // R01
                    req_q[`SYNC_SECONDARY]  <= ~req_q[`SYNC_SECONDARY];
                end
            end
            if (wrOk && paddr == `OFS_ADDRESS_MATCH)
                addrMatch_q <= pwdata;
            if (wrOk && paddr == `OFS_IRQ_ENABLE_SET)
                irqEnable <= irqEnable | (pwdata[7:0] & `IRQ_EN_WRITABLE); // R15 R16 R17
        end
    end

    // request toggles into the core stage, acknowledge toggles back
    always @(posedge mclk) begin
        if (!reset_n) begin
            reqS1_q <= {`SYNC_CHANNELS{1'b0}};
            reqS2_q <= {`SYNC_CHANNELS{1'b0}};
            ack_q   <= {`SYNC_CHANNELS{1'b0}};
            ackS1_q <= {`SYNC_CHANNELS{1'b0}};
            ackS2_q <= {`SYNC_CHANNELS{1'b0}};
        end else begin
            reqS1_q <= req_q;
            reqS2_q <= reqS1_q;
            ack_q   <= reqS2_q;                              // R18
            ackS1_q <= ack_q;
            ackS2_q <= ackS1_q;
        end
    end

    // core copies only change when their request arrives; bus values are frozen while busy
    always @(posedge mclk) begin
        if (!reset_n || coreSeen[`SYNC_SOFT_RESET]) begin
            coreEnable_q    <= 1'b0;
            coreSecondary_q <= `RST_SECONDARY_CONTROL;
        end else begin
            if (coreSeen[`SYNC_ENABLE])
                coreEnable_q <= primary_q[`BIT_ENABLE];
            if (coreSeen[`SYNC_SECONDARY])
                coreSecondary_q <= secondary_q;
        end
    end

    // register read mux, unmapped offsets read zero
    always @* begin
        case (paddr)
            `OFS_PRIMARY_CONTROL:   prdata = primary_q;
            `OFS_SECONDARY_CONTROL: prdata = secondary_q;
            `OFS_IRQ_ENABLE_SET:    prdata = {24'h000000, irqEnable};
            `OFS_SYNC_STATUS:       prdata = {29'h00000000, busy_q};
            `OFS_ADDRESS_MATCH:     prdata = addrMatch_q;
            default:                prdata = 32'h00000000;
        endcase
    end

    // link pins: three flops, a change counts when stages two and three agree
    reg  [5:0] pinS1_q;
    reg  [5:0] pinS2_q;
    reg  [5:0] pinS3_q;
    reg  [5:0] pinF_q;
    reg        sckPrev_q;
    wire [5:0] pinRaw;

    assign pinRaw = {sck, selectN, pad};

    always @(posedge mclk) begin
        if (!reset_n) begin
            pinS1_q   <= 6'h10;
            pinS2_q   <= 6'h10;
            pinS3_q   <= 6'h10;
            pinF_q    <= 6'h10;
            sckPrev_q <= 1'b0;
        end else begin
            pinS1_q   <= pinRaw;
            pinS2_q   <= pinS1_q;
            pinS3_q   <= pinS2_q;
            pinF_q    <= (pinF_q & (pinS2_q ^ pinS3_q)) | (pinS2_q & ~(pinS2_q ^ pinS3_q));
            sckPrev_q <= pinF_q[5];
        end
    end

    wire       sckF      = pinF_q[5];
    wire       selected  = ~pinF_q[4];
    wire       clock_polarity      = primary_q[`BIT_CLOCK_POLARITY];
    wire       clock_phase      = primary_q[`BIT_CLOCK_PHASE];
    wire       lsbFirst  = primary_q[`BIT_DATA_ORDER];
    wire [3:0] format    = primary_q[`FRAME_FORMAT_HI:`FRAME_FORMAT_LO];
    wire [1:0] pinout    = primary_q[`DATA_IN_PINOUT_HI:`DATA_IN_PINOUT_LO];
    wire       sckEdge   = sckF ^ sckPrev_q;
    // leading edge leaves the idle level
    wire       leading   = sckEdge & (sckPrev_q == clock_polarity);   // R08
    wire       trailing  = sckEdge & (sckPrev_q != clock_polarity);   // R08
    wire       sampleEdg = clock_phase ? trailing : leading;        // R09
    wire       changeEdg = clock_phase ? leading : trailing;        // R09
    wire       serialIn  = pinF_q[pinout];                   // R13
    wire       active    = selected & coreEnable_q & coreSecondary_q[`BIT_RX_ENABLE];
    wire       addrMode  = (format == `FORMAT_WITH_ADDRESS); // R11
    wire       known     = (format == `FORMAT_PLAIN) | addrMode;

    reg  [7:0] rxShift_q;
    reg  [7:0] txShift_q;
    reg  [2:0] bitCnt_q;
    reg        firstByte_q;
    reg        dropFrame_q;
    reg        pushValid_q;
    reg  [7:0] pushData_q;
    reg        selPrev_q;
    wire [7:0] rxNext;
    wire       pushReady;

    assign rxNext = lsbFirst ? {serialIn, rxShift_q[7:1]} : {rxShift_q[6:0], serialIn}; // R07

    // receive shifter, address check and hand-off to the buffer
    always @(posedge mclk) begin
        if (!reset_n) begin
            rxShift_q   <= 8'h00;
            bitCnt_q    <= 3'd0;
            firstByte_q <= 1'b1;
            dropFrame_q <= 1'b0;
            pushValid_q <= 1'b0;
            pushData_q  <= 8'h00;
            rxOverflow  <= 1'b0;
            selPrev_q   <= 1'b0;
        end else begin
            selPrev_q <= selected;
            if (pushValid_q && pushReady)
                pushValid_q <= 1'b0;
            // clear comes first so a loss in the same cycle still shows
            if (wrOk && hitPrimary)
                rxOverflow <= 1'b0;
            if (!active) begin
                bitCnt_q    <= 3'd0;
                firstByte_q <= 1'b1;
                dropFrame_q <= 1'b0;
            end else if (sampleEdg && known) begin
                rxShift_q <= rxNext;
                bitCnt_q  <= bitCnt_q + 3'd1;
                if (bitCnt_q == 3'd7) begin
                    firstByte_q <= 1'b0;
                    if (addrMode && firstByte_q)
                        dropFrame_q <= (rxNext != addrMatch_q[7:0]); // R12
                    else if (!dropFrame_q) begin
                        // spi cannot be held off, so a word with no room is counted lost
                        if (pushValid_q && !pushReady)
                            rxOverflow <= 1'b1;
                        else begin
                            pushValid_q <= 1'b1;
                            pushData_q  <= rxNext;
                        end
                    end
                end
            end
        end
    end

    // transmit shifter reloads at each byte boundary and drives only while selected
    always @(posedge mclk) begin
        if (!reset_n) begin
            txShift_q <= 8'h00;
            misoOut   <= 1'b0;
            misoOe    <= 1'b0;
        end else begin
            misoOe <= active;
            if (selected && !selPrev_q)
                txShift_q <= txData;
            else if (active && changeEdg) begin
                if (bitCnt_q == 3'd0)
                    txShift_q <= txData;
                else if (lsbFirst)
                    txShift_q <= {1'b0, txShift_q[7:1]};     // R07
                else
                    txShift_q <= {txShift_q[6:0], 1'b0};     // R07
            end
            misoOut <= lsbFirst ? txShift_q[0] : txShift_q[7];
        end
    end

    fifo2 rxBuffer (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .flush    (coreSeen[`SYNC_SOFT_RESET]),
        .inValid  (pushValid_q),
        .inReady  (pushReady),
        .inData   (pushData_q),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (rxData)
    );
endmodule // serial_unit

// ---- serial_unit_properties.sv ----
// concurrent checks on the serial unit register bus, sync busy flags and irq enables
`timescale 1ns/1ps
module serial_unit_properties (
    input wire        mclk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire [7:0]  irqEnable
);
    wire acc    = psel && penable;
    wire wrOk   = acc && pwrite && !pslverr;
    wire srWr   = wrOk && paddr == 8'h00 && pwdata[0];
    wire rdSync = acc && !pwrite && paddr == 8'h1C;
    reg  enQ;
    // bus copy of enable; a soft reset always ends disabled, and writes meanwhile are refused
    always @(posedge mclk) begin
        if (!reset_n || srWr)
            enQ <= 1'b0;
        else if (wrOk && paddr == 8'h00)
            enQ <= pwdata[1];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence srWr_s; srWr; endsequence
    sequence enWr_s; wrOk && paddr == 8'h00 && !pwdata[0] && pwdata[1] != enQ; endsequence
    sequence c2Wr_s; wrOk && paddr == 8'h04 && enQ; endsequence
    sequence calmWr_s; wrOk && paddr == 8'h00 && !pwdata[0] && pwdata[1] == enQ; endsequence
    chk_err_on_write: assert property (pslverr |-> acc && pwrite)
        else $error("error response outside a write access");
    chk_sr_busy: assert property (srWr_s ##[1:4] rdSync |-> prdata[0])
        else $error("reset busy flag not set after soft reset write");
    chk_sr_discard: assert property (srWr_s ##[1:4] (acc && pwrite) |-> pslverr)
        else $error("write accepted during reset sync");
    chk_en_discard: assert property (enWr_s ##[1:4] (acc && pwrite && paddr != 8'h00) |-> pslverr)
        else $error("write accepted during enable sync");
    chk_en_keep_irq: assert property (enWr_s ##[1:4] (acc && pwrite && paddr == 8'h16)
        |=> irqEnable == $past(irqEnable))
        else $error("discarded write changed irq enables");
    chk_c2_refuse: assert property (c2Wr_s ##[1:4] (acc && pwrite && paddr == 8'h04) |-> pslverr)
        else $error("secondary control rewritten while busy");
    chk_irq_set: assert property (wrOk && paddr == 8'h16
        |=> irqEnable == ($past(irqEnable) | (8'h83 & $past(pwdata[7:0]))))
        else $error("irq enable set register misbehaved");
    chk_no_sync: assert property ((rdSync && prdata[2:0] == 3'h0) ##[2:3] calmWr_s
        ##[2:3] rdSync |-> prdata[2:0] == 3'h0)
        else $error("frame setting write raised a busy flag");
endmodule // serial_unit_properties

bind serial_unit serial_unit_properties chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .irqEnable(irqEnable));

// ---- spi_master_model.sv ----
// behavioural spi master that drives the serial clock, select and data pads
`timescale 1ns/1ps
module spi_master_model (
    output reg       sck,
    output reg       selectN,
    output reg [3:0] pad
);
    reg pol;
    initial begin
        sck = 1'b0;
        selectN = 1'b1;
        pad = 4'h5;
        pol = 1'b0;
    end
    // clock parks at the polarity level before select falls and stands still between frames
    task frameStart(input p);
        begin
            pol = p;
            sck = p;
            #800 selectN = 1'b0;
            #800;
        end
    endtask
    // released pads flip so a stale value never looks like data
    task frameEnd;
        begin
            #800 selectN = 1'b1;
            pad = ~pad;
            #1600;
        end
    endtask
    // unused pads carry the inverse bit, so a wrong pad choice corrupts the byte
    task sendByte(input [7:0] b, input ph, input lsbFirst, input [1:0] line);
        integer i;
        reg     bitV;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                bitV = lsbFirst ? b[i] : b[7-i];
                if (!ph) pad = bitV ? (4'h1 << line) : ~(4'h1 << line);
                #400 sck = ~pol;
                if (ph) pad = bitV ? (4'h1 << line) : ~(4'h1 << line);
                #400 sck = pol;
            end
        end
    endtask
endmodule // spi_master_model

// ---- serial_unit_test.sv ----
// self-checking bench for the serial unit register bus and spi receive path
`timescale 1ns/1ps
`include "serial_unit_defs.vh"
module serial_unit_test;
    reg         mclk, reset_n, psel, penable, pwrite, rxReady;
    reg  [7:0]  paddr, txData;
    reg  [31:0] pwdata, r, ctl;
    reg         e;
    wire [31:0] prdata;
    wire        pready, pslverr, misoOut, misoOe, rxValid, rxOverflow, sck, selectN;
    wire [3:0]  pad;
    wire [7:0]  rxData, irqEnable;
    integer     errors, n_compared, i;
    serial_unit uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck(sck), .selectN(selectN), .pad(pad), .misoOut(misoOut),
        .misoOe(misoOe), .txData(txData), .rxValid(rxValid), .rxReady(rxReady),
        .rxData(rxData), .rxOverflow(rxOverflow), .irqEnable(irqEnable));
    spi_master_model spi (.sck(sck), .selectN(selectN), .pad(pad));
    // 100 ns clock
    always #50 mclk = ~mclk;
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chkReg(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t value %h expected %h", $time, got, exp);
            end
        end
    endtask
    task chkBit(input got, input exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    // one access: setup cycle, access cycle, answer taken at the edge that sees ready high
    task apb(input w, input [7:0] a, input [31:0] d, output [31:0] rd, output er);
        integer k;
        begin
            @(posedge mclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            for (k = 0; k < 8 && pready !== 1'b1; k = k + 1)
                @(posedge mclk);
            if (pready !== 1'b1) begin
                errors = errors + 1;
                $display("[FAIL] %0t bus never ready", $time);
                final_report;
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // let the edge settle so callers see what the access did
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input expErr);
        begin
            apb(1'b1, a, d, r, e);
            chkBit(e, expErr);
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0, r, e);
            chkReg(r, exp);
        end
    endtask
    // polls sync status under a bound; running out ends the run
    task waitIdle;
        integer k;
        begin
            r = 32'hF;
            for (k = 0; k < 40 && r !== 32'h0; k = k + 1)
                apb(1'b0, `OFS_SYNC_STATUS, 32'h0, r, e);
            if (r !== 32'h0) begin
                errors = errors + 1;
                $display("[FAIL] %0t sync never went idle", $time);
                final_report;
            end
        end
    endtask
    // byte waits in the buffer because ready is held low until it is checked
    task getByte(input [7:0] exp);
        integer k;
        begin
            for (k = 0; k < 300 && rxValid !== 1'b1; k = k + 1)
                @(posedge mclk);
            if (rxValid !== 1'b1) begin
                errors = errors + 1;
                $display("[FAIL] %0t no byte arrived", $time);
                final_report;
            end
            chkReg({24'h0, rxData}, {24'h0, exp});
            @(posedge mclk);
            rxReady <= 1'b1;
            @(posedge mclk);
            rxReady <= 1'b0;
            // the pop lands at this edge, so the next look waits for it
            #1;
        end
    endtask
    task noByte;
        begin
            repeat (40) @(posedge mclk);
            #1;
            chkBit(rxValid, 1'b0);
        end
    endtask
    task frame(input [7:0] b0, input [7:0] b1, input two);
        begin
            spi.frameStart(1'b0);
            spi.sendByte(b0, 1'b0, 1'b0, 2'h0);
            if (two) spi.sendByte(b1, 1'b0, 1'b0, 2'h0);
            spi.frameEnd;
        end
    endtask
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rxReady = 1'b0;
        txData = 8'hC3;
        errors = 0;
        n_compared = 0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`OFS_PRIMARY_CONTROL, `RST_PRIMARY_CONTROL);
        rd(`OFS_SECONDARY_CONTROL, `RST_SECONDARY_CONTROL);
        rd(`OFS_ADDRESS_MATCH, `RST_ADDRESS_MATCH);
        rd(`OFS_SYNC_STATUS, 32'h0);
        $display("test reset values done");
        wr(`OFS_IRQ_ENABLE_SET, 32'h01, 1'b0);
        chkReg(irqEnable, 32'h01);
        wr(`OFS_IRQ_ENABLE_SET, 32'h02, 1'b0);
        chkReg(irqEnable, 32'h03);
        wr(`OFS_IRQ_ENABLE_SET, 32'h00, 1'b0);
        chkReg(irqEnable, 32'h03);
        wr(`OFS_IRQ_ENABLE_SET, 32'hFF, 1'b0);
        chkReg(irqEnable, 32'h83);
        $display("test irq enable set done");
        wr(`OFS_PRIMARY_CONTROL, 32'h1, 1'b0);
        wr(`OFS_ADDRESS_MATCH, 32'h5A, 1'b1);
        waitIdle;
        rd(`OFS_ADDRESS_MATCH, 32'h0);
        chkReg(irqEnable, 32'h0);
        wr(`OFS_ADDRESS_MATCH, 32'hA5, 1'b0);
        rd(`OFS_ADDRESS_MATCH, 32'hA5);
        $display("test soft reset done");
        wr(`OFS_PRIMARY_CONTROL, 32'h2, 1'b0);
        wr(`OFS_IRQ_ENABLE_SET, 32'h80, 1'b1);
        chkReg(irqEnable, 32'h0);
        waitIdle;
        wr(`OFS_SECONDARY_CONTROL, 32'h20000, 1'b0);
        wr(`OFS_SECONDARY_CONTROL, 32'h20000, 1'b1);
        waitIdle;
        $display("test enable and secondary sync done");
        // every polarity and phase, both bit orders, every input pad
        for (i = 0; i < 4; i = i + 1) begin
            ctl = 32'h2 | (i[1] << 29) | (i[0] << 28) | ((i[0] ^ i[1]) << 30) | (i << 20);
            waitIdle;
            wr(`OFS_PRIMARY_CONTROL, ctl, 1'b0);
            rd(`OFS_SYNC_STATUS, 32'h0);
            spi.frameStart(i[1]);
            spi.sendByte(8'hB1 + i * 8'h13, i[0], i[0] ^ i[1], i[1:0]);
            spi.frameEnd;
            getByte(8'hB1 + i * 8'h13);
        end
        $display("test spi modes done");
        wr(`OFS_PRIMARY_CONTROL, 32'h2 | (`FORMAT_WITH_ADDRESS << 24), 1'b0);
        frame(8'hA5, 8'h3C, 1'b1);
        getByte(8'h3C);
        frame(8'h5A, 8'h77, 1'b1);
        noByte;
        wr(`OFS_PRIMARY_CONTROL, 32'h2 | (32'h1 << 24), 1'b0);
        frame(8'h11, 8'h00, 1'b0);
        noByte;
        $display("test frame formats done");
        // four bytes with the receiver stalled: buffer and hand-off stage hold three, the fourth is lost
        wr(`OFS_PRIMARY_CONTROL, 32'h2, 1'b0);
        spi.frameStart(1'b0);
        chkBit(misoOe, 1'b1);
        chkBit(misoOut, txData[7]);
        spi.sendByte(8'h01, 1'b0, 1'b0, 2'h0);
        spi.sendByte(8'h02, 1'b0, 1'b0, 2'h0);
        spi.sendByte(8'h03, 1'b0, 1'b0, 2'h0);
        spi.sendByte(8'h04, 1'b0, 1'b0, 2'h0);
        spi.frameEnd;
        chkBit(misoOe, 1'b0);
        chkBit(rxOverflow, 1'b1);
        getByte(8'h01);
        getByte(8'h02);
        getByte(8'h03);
        noByte;
        $display("test buffer stall done");
        wr(`OFS_PRIMARY_CONTROL, 32'h0, 1'b0);
        wr(`OFS_PRIMARY_CONTROL, 32'h1, 1'b0);
        apb(1'b0, `OFS_SYNC_STATUS, 32'h0, r, e);
        chkBit(r[0], 1'b1);
        waitIdle;
        rd(`OFS_PRIMARY_CONTROL, 32'h0);
        $display("test reset during enable sync done");
        final_report;
    end
endmodule // serial_unit_test
